// ### src/acp_axis.sv
/*
  Speed-profile axis: APB registers, parameter check and correction,
  256-level linear or S-curve transitions, pulse and direction outputs.
  Assumes a 100 MHz pclk; the motor driver takes pulse and direction.
*/
// Summary of operation
// - rate form after reset; format bit selects time
// - time form counts 10 ms steps
// - time values 8..4095 always accepted
// - plus and minus acceleration held separately
// - upper speed up to 11 kpps allows 7
// - 8 kpps allows 6, 5 kpps allows 5
// - bad acceleration errors when correction off
// - bad speeds error when correction off
// - correction on clamps speeds and acceleration silently
// - width under 32 errors for basic transitions
// - pattern with narrow width runs at lower speed
// - correction bit toggles correction, on at reset
// - curve bit picks linear or S-curve
// - one curve serves both directions
// - S-curve after reset
// - full transition is 255 equal steps
// - reversal retraces exactly the climbed levels
// - instructions run in sequence with new parameters
// - rate form accepts 1..1542 per 10 ms
// - rate transition under 80 ms errors or stretches
// - rate transition capped at 40.95 s
`timescale 1ns/1ns
module acp_axis
  import acp_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // motor driver
  output logic pulse_out,
  output logic dir_out
);
  import acp_pkg::*;

  localparam int LEVEL_CYC = TICK_CYCLES / LEVELS;

  initial
  begin
    if (TICK_CYCLES < LEVELS) $error("acp_axis: TICK_CYCLES below 256");
  end

  logic curve_s;
  logic accel_format_select_bit;
  logic auto_correct_enable_bit;
  logic [1:0] speed_range;
  logic [15:0] low_set;
  logic [15:0] up_set;
  logic [11:0] pacc_set;
  logic [11:0] macc_set;
  logic err_flag;
  logic [3:0] err_code;
  acp_state_t state;
  logic [7:0] level;
  logic pattern_run;
  logic [15:0] eff_low;
  logic [15:0] eff_up;
  logic [31:0] acc_per;
  logic [31:0] dec_per;
  logic [15:0] cur_speed;
  logic [26:0] phase;
  logic tick;
  logic access;
  logic wr;
  logic cmd_go;
  logic mapped;
  logic [31:0] rdata_c;

  function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // returns {bad, time in 10 ms units}
  function automatic logic [16:0] xfer_time(input logic [11:0] v, input logic tfmt,
                                            input logic [15:0] w, input logic [15:0] up);
    logic [15:0] r;
    logic [15:0] t;
    logic [15:0] tmin;
    logic bad;
    r = 16'h0000;
    t = 16'h0000;
    tmin = TIME_MIN;
    bad = 1'b0;
    if (tfmt)
    begin
      if (up <= UP_5K) tmin = TIME_MIN_5K;
      else if (up <= UP_8K) tmin = TIME_MIN_8K;
      else if (up <= UP_11K) tmin = TIME_MIN_11K;
      t = {4'h0, v};
      if (t < tmin)
      begin
        bad = 1'b1;
        t = tmin;
      end
    end
    else
    begin
      r = clamp16({4'h0, v}, RATE_MIN, RATE_MAX);
      bad = (r != {4'h0, v});
      t = (w + r - 16'h0001) / r;
      // stretch short transitions to 80 ms
      if (t < TIME_MIN)
      begin
        bad = 1'b1;
        t = TIME_MIN;
      end
      // cap at 40.95 s without error
      if (t > TIME_MAX) t = TIME_MAX;
    end
    xfer_time = {bad, t};
  endfunction

  // 0..255 shape of a level, linear or smoothstep
  function automatic logic [7:0] shape(input logic [7:0] l, input logic s);
    logic [31:0] l2;
    logic [31:0] v;
    l2 = 32'(l) * 32'(l);
    v = (32'd3 * l2 * 32'd255 - 32'd2 * l2 * 32'(l)) / 32'd65025;
    shape = s ? v[7:0] : l;
  endfunction

  // parameter check and correction
  logic [15:0] rmin;
  logic [15:0] rmax;
  logic [15:0] lo_c;
  logic [15:0] up_c;
  logic [15:0] width;
  logic spd_bad;
  logic [16:0] pt;
  logic [16:0] mt;
  logic par_bad;
  logic narrow;

  always_comb
  begin
    case (speed_range)
      2'h0:
      begin
        rmin = R0_MIN;
        rmax = R0_MAX;
      end
      2'h1:
      begin
        rmin = R1_MIN;
        rmax = R1_MAX;
      end
      default:
      begin
        rmin = R2_MIN;
        rmax = R2_MAX;
      end
    endcase
    lo_c = clamp16(low_set, rmin, rmax);
    up_c = clamp16(up_set, rmin, rmax);
    spd_bad = (lo_c != low_set) || (up_c != up_set) || (lo_c > up_c);
    if (lo_c > up_c) lo_c = up_c;
    width = up_c - lo_c;
    pt = xfer_time(pacc_set, accel_format_select_bit, width, up_c);
    mt = xfer_time(macc_set, accel_format_select_bit, width, up_c);
    par_bad = spd_bad || pt[16] || mt[16];
    narrow = width < WIDTH_MIN;
  end

  // apb handshake, one wait state
  assign access = psel && penable && !pready;
  assign wr = psel && penable && pready && pwrite;
  assign cmd_go = wr && (paddr == OFS_CMD);

  always_comb
  begin
    mapped = 1'b1;
    rdata_c = 32'h0000_0000;
    case (paddr)
      OFS_PROP1: rdata_c[P1_CURVE_BIT] = curve_s;
      OFS_PROP2:
      begin
        rdata_c[P2_FORMAT_BIT] = accel_format_select_bit;
        rdata_c[P2_AUTOCORR_BIT] = auto_correct_enable_bit;
        rdata_c[P2_RANGE_LSB +: 2] = speed_range;
      end
      OFS_LOW: rdata_c[15:0] = low_set;
      OFS_UP: rdata_c[15:0] = up_set;
      OFS_PACC: rdata_c[11:0] = pacc_set;
      OFS_MACC: rdata_c[11:0] = macc_set;
      OFS_CMD: rdata_c[CMD_DIR_BIT] = dir_out;
      OFS_STAT:
      begin
        rdata_c[STAT_ERR_BIT] = err_flag;
        rdata_c[STAT_CODE_LSB +: 4] = err_code;
        rdata_c[STAT_STATE_LSB +: 3] = state;
        rdata_c[STAT_LEVEL_LSB +: 8] = level;
      end
      OFS_SPEED: rdata_c[15:0] = cur_speed;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= access;
      pslverr <= access && !mapped;
      if (access) prdata <= rdata_c;
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      curve_s <= RST_CURVE;
      accel_format_select_bit <= RST_FORMAT;
      auto_correct_enable_bit <= RST_AUTOCORR;
      speed_range <= RST_RANGE;
      low_set <= RST_LOW;
      up_set <= RST_UP;
      pacc_set <= RST_ACC;
      macc_set <= RST_ACC;
    end
    else if (wr)
    begin
      case (paddr)
        OFS_PROP1: curve_s <= pwdata[P1_CURVE_BIT];
        OFS_PROP2:
        begin
          accel_format_select_bit <= pwdata[P2_FORMAT_BIT];
          auto_correct_enable_bit <= pwdata[P2_AUTOCORR_BIT];
          speed_range <= pwdata[P2_RANGE_LSB +: 2];
        end
        OFS_LOW: low_set <= pwdata[15:0];
        OFS_UP: up_set <= pwdata[15:0];
        OFS_PACC: pacc_set <= pwdata[11:0];
        OFS_MACC: macc_set <= pwdata[11:0];
        default: ;
      endcase
    end
  end

  // instruction decode
  logic [3:0] next_err;
  logic accept;

  always_comb
  begin
    next_err = ERR_NONE;
    case (pwdata[2:0])
      CMD_STOP: next_err = ERR_NONE;
      CMD_LOWER, CMD_UPPER:
        if (state == ST_DSTOP) next_err = ERR_ORDER;
      CMD_ACCEL:
        if (state == ST_ACC || state == ST_DSTOP) next_err = ERR_ORDER;
      CMD_DECEL:
        if (state == ST_DEC || state == ST_DSTOP || state == ST_STOP) next_err = ERR_ORDER;
      CMD_DSTOP:
        if (state == ST_STOP) next_err = ERR_ORDER;
      CMD_PATTERN:
        if (state != ST_STOP) next_err = ERR_ORDER;
      default: next_err = ERR_ORDER;
    endcase
    if (next_err == ERR_NONE && pwdata[2:0] != CMD_STOP)
    begin
      if (par_bad && !auto_correct_enable_bit) next_err = ERR_PARAM;
      else if (narrow && (pwdata[2:0] == CMD_ACCEL || pwdata[2:0] == CMD_DECEL ||
               pwdata[2:0] == CMD_DSTOP)) next_err = ERR_WIDTH;
    end
    accept = cmd_go && (next_err == ERR_NONE);
  end

  // sticky error, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_flag <= 1'b0;
      err_code <= ERR_NONE;
    end
    else if (cmd_go && next_err != ERR_NONE)
    begin
      err_flag <= 1'b1;
      err_code <= next_err;
    end
    else if (wr && paddr == OFS_STAT && pwdata[STAT_ERR_BIT])
    begin
      err_flag <= 1'b0;
      err_code <= ERR_NONE;
    end
  end

  // motion state and levels
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ST_STOP;
      level <= 8'h00;
      pattern_run <= 1'b0;
      eff_low <= RST_LOW;
      eff_up <= RST_UP;
      acc_per <= 32'h0000_0001;
      dec_per <= 32'h0000_0001;
      dir_out <= 1'b0;
    end
    else if (accept)
    begin
      eff_low <= lo_c;
      eff_up <= up_c;
      acc_per <= 32'(pt[15:0]) * 32'(LEVEL_CYC);
      dec_per <= 32'(mt[15:0]) * 32'(LEVEL_CYC);
      pattern_run <= 1'b0;
      if (state == ST_STOP) dir_out <= pwdata[CMD_DIR_BIT];
      case (pwdata[2:0])
        CMD_STOP:
        begin
          state <= ST_STOP;
          level <= 8'h00;
        end
        CMD_LOWER:
        begin
          state <= ST_LOW;
          level <= 8'h00;
        end
        CMD_UPPER:
        begin
          state <= ST_UP;
          level <= LEVEL_TOP;
        end
        CMD_ACCEL: state <= ST_ACC;
        CMD_DECEL: state <= ST_DEC;
        CMD_DSTOP: state <= ST_DSTOP;
        default:
        begin
          // narrow pattern runs flat at lower speed
          level <= 8'h00;
          if (narrow) state <= ST_LOW;
          else
          begin
            state <= ST_ACC;
            pattern_run <= 1'b1;
          end
        end
      endcase
    end
    else if (tick)
    begin
      case (state)
        ST_ACC:
        begin
          level <= level + 8'h01;
          if (level + 8'h01 == LEVEL_TOP) state <= pattern_run ? ST_DSTOP : ST_UP;
        end
        ST_DEC:
        begin
          level <= level - 8'h01;
          if (level == 8'h01) state <= ST_LOW;
        end
        ST_DSTOP:
        begin
          level <= level - 8'h01;
          if (level == 8'h01) state <= ST_STOP;
        end
        default: ;
      endcase
    end
    else if (state == ST_DSTOP && level == 8'h00)
    begin
      state <= ST_STOP;
    end
    // nothing left to climb or descend
    else if (state == ST_ACC && level == LEVEL_TOP)
    begin
      state <= ST_UP;
    end
    else if (state == ST_DEC && level == 8'h00)
    begin
      state <= ST_LOW;
    end
  end

  logic ramping;
  assign ramping = (state == ST_ACC) || (state == ST_DEC) || (state == ST_DSTOP);

  acp_level_timer #(
    .CW(32)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .restart(accept),
    .run(ramping),
    .period((state == ST_ACC) ? acc_per : dec_per),
    .tick(tick)
  );

  // speed from level; one curve for both directions
  logic [15:0] next_speed;
  logic [23:0] prod;

  always_comb
  begin
    prod = 24'(eff_up - eff_low) * 24'(shape(level, curve_s));
    next_speed = eff_low + 16'(prod / 24'd255);
    if (state == ST_STOP) next_speed = 16'h0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) cur_speed <= 16'h0000;
    else cur_speed <= next_speed;
  end

  // pulse generation by phase accumulation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase <= 27'h000_0000;
      pulse_out <= 1'b0;
    end
    else if (state == ST_STOP)
    begin
      phase <= 27'h000_0000;
      pulse_out <= 1'b0;
    end
    else if (phase + 27'(cur_speed) >= HALF_HZ)
    begin
      phase <= phase + 27'(cur_speed) - HALF_HZ;
      pulse_out <= !pulse_out;
    end
    else
    begin
      phase <= phase + 27'(cur_speed);
    end
  end

  AST_ACC_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    (state == ST_ACC && tick && !accept) |=> level == $past(level) + 8'h01)
    else $error("level did not climb on tick");

  AST_LEVEL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (!tick && !accept && ramping) |=> level == $past(level))
    else $error("level moved without tick");

  AST_REVERSE: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && state == ST_ACC && pwdata[2:0] == CMD_DECEL) |=> (state == ST_DEC &&
      level == $past(level)))
    else $error("reversal lost levels");

  AST_WIDTH_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && pwdata[2:0] == CMD_ACCEL && narrow && state == ST_STOP &&
      auto_correct_enable_bit) |=> (err_flag && err_code == ERR_WIDTH && state == ST_STOP))
    else $error("narrow accelerate not refused");

  AST_PATTERN_FLAT: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && pwdata[2:0] == CMD_PATTERN && narrow && state == ST_STOP &&
      auto_correct_enable_bit && !err_flag) |=> (state == ST_LOW && !err_flag))
    else $error("narrow pattern not run flat");

  AST_PARAM_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && pwdata[2:0] == CMD_LOWER && par_bad && !auto_correct_enable_bit &&
      state == ST_STOP) |=> (err_code == ERR_PARAM && state == ST_STOP))
    else $error("bad parameter accepted");

  AST_LOW_CLAMP: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> (eff_low >= rmin && eff_up <= rmax && eff_low <= eff_up))
    else $error("speeds not clamped");

  AST_TIME_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    accept |-> (pt[15:0] >= TIME_MIN_5K && pt[15:0] <= TIME_MAX &&
      mt[15:0] <= TIME_MAX))
    else $error("transition time out of range");

  AST_ERR_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
    (err_flag && !(wr && paddr == OFS_STAT)) |=> err_flag)
    else $error("error flag lost");

  AST_STOP_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
    (accept && pwdata[2:0] == CMD_STOP) |=> ##1 (!pulse_out && cur_speed == 16'h0000))
    else $error("stop did not halt pulses");
endmodule

// ### src/acp_level_timer.sv
/*
  Level timer: one-cycle tick every period cycles while run is high.
  Assumes period is stable between restarts; a period of zero acts as one.
*/
`timescale 1ns/1ns
module acp_level_timer #(
  parameter int CW = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  input wire logic run,
  input wire logic [CW-1:0] period,
  // event
  output logic tick
);
  logic [CW-1:0] count;

  initial
  begin
    if (CW < 8) $error("acp_level_timer: CW too small");
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else if (restart || !run)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else if (count + CW'(1) >= period)
    begin
      count <= '0;
      tick <= 1'b1;
    end
    else
    begin
      count <= count + CW'(1);
      tick <= 1'b0;
    end
  end
endmodule

// ### src/acp_pkg.sv
/*
  Package for the axis speed-profile block: register offsets, field
  positions, reset values, limits, timing counts and the state type.
  Assumes a 100 MHz pclk and an APB master with 32-bit data.
*/
package acp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_PROP1 = 8'h00;
  localparam logic [7:0] OFS_PROP2 = 8'h04;
  localparam logic [7:0] OFS_LOW = 8'h08;
  localparam logic [7:0] OFS_UP = 8'h0C;
  localparam logic [7:0] OFS_PACC = 8'h10;
  localparam logic [7:0] OFS_MACC = 8'h14;
  localparam logic [7:0] OFS_CMD = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_SPEED = 8'h20;
  // field positions
  localparam int P1_CURVE_BIT = 0;
  localparam int P2_FORMAT_BIT = 0;
  localparam int P2_AUTOCORR_BIT = 1;
  localparam int P2_RANGE_LSB = 2;
  localparam int CMD_DIR_BIT = 4;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_CODE_LSB = 4;
  localparam int STAT_STATE_LSB = 8;
  localparam int STAT_LEVEL_LSB = 16;
  // reset values
  localparam logic RST_CURVE = 1'b1;
  localparam logic RST_FORMAT = 1'b0;
  localparam logic RST_AUTOCORR = 1'b1;
  localparam logic [1:0] RST_RANGE = 2'h2;
  localparam logic [15:0] RST_LOW = 16'h00A0;
  localparam logic [15:0] RST_UP = 16'h01F4;
  localparam logic [11:0] RST_ACC = 12'h0064;
  // instruction codes
  localparam logic [2:0] CMD_STOP = 3'h0;
  localparam logic [2:0] CMD_LOWER = 3'h1;
  localparam logic [2:0] CMD_UPPER = 3'h2;
  localparam logic [2:0] CMD_ACCEL = 3'h3;
  localparam logic [2:0] CMD_DECEL = 3'h4;
  localparam logic [2:0] CMD_DSTOP = 3'h5;
  localparam logic [2:0] CMD_PATTERN = 3'h6;
  // error codes
  localparam logic [3:0] ERR_NONE = 4'h0;
  localparam logic [3:0] ERR_PARAM = 4'h1;
  localparam logic [3:0] ERR_WIDTH = 4'h2;
  localparam logic [3:0] ERR_ORDER = 4'h3;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int STEP_MS = 10;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * STEP_MS;
  localparam int LEVELS = 256;
  localparam logic [7:0] LEVEL_TOP = 8'hFF;
  localparam logic [26:0] HALF_HZ = 27'(CLK_HZ / 2);
  // acceleration limits
  localparam logic [15:0] RATE_MIN = 16'h0001;
  localparam logic [15:0] RATE_MAX = 16'h0606;
  localparam logic [15:0] TIME_MIN = 16'h0008;
  localparam logic [15:0] TIME_MAX = 16'h0FFF;
  localparam logic [15:0] WIDTH_MIN = 16'h0020;
  localparam logic [15:0] UP_11K = 16'h2AF8;
  localparam logic [15:0] UP_8K = 16'h1F40;
  localparam logic [15:0] UP_5K = 16'h1388;
  localparam logic [15:0] TIME_MIN_11K = 16'h0007;
  localparam logic [15:0] TIME_MIN_8K = 16'h0006;
  localparam logic [15:0] TIME_MIN_5K = 16'h0005;
  // speed ranges in pps
  localparam logic [15:0] R0_MIN = 16'h000A;
  localparam logic [15:0] R0_MAX = 16'h09C4;
  localparam logic [15:0] R1_MIN = 16'h0028;
  localparam logic [15:0] R1_MAX = 16'h2710;
  localparam logic [15:0] R2_MIN = 16'h00A0;
  localparam logic [15:0] R2_MAX = 16'h30D4;

  typedef enum logic [2:0] {ST_STOP, ST_LOW, ST_UP, ST_ACC, ST_DEC, ST_DSTOP} acp_state_t;
endpackage

// ### test/acp_motor_model.sv
/*
  Motor driver stand-in: counts step pulses and keeps the direction
  seen at the last step. Assumes pulse and direction from the axis.
*/
`timescale 1ns/1ns
module acp_motor_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // step interface
  input wire logic pulse_in,
  input wire logic dir_in
);
  int pulses;
  logic last_dir;
  // count steps, latch direction
  always @(posedge pulse_in or negedge presetn)
  begin
    if (!presetn)
    begin
      pulses <= 0;
      last_dir <= 1'b0;
    end
    else
    begin
      pulses <= pulses + 1;
      last_dir <= dir_in;
    end
  end
endmodule

// ### test/tb_acp_axis.sv
/*
  Bench for the speed-profile axis: register defaults, parameter checks,
  timed ramps, reversal, curve shape and step output.
  Assumes TICK_CYCLES of 2560: one 10 ms unit is ten cycles a level.
*/
`timescale 1ns/1ns
module tb_acp_axis;
  import acp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pulse_out;
  logic dir_out;
  logic perr;
  logic [31:0] s;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  int lvl;
  int up;
  int a;
  logic f;
  logic [7:0] ra[9] = '{OFS_PROP1, OFS_PROP2, OFS_LOW, OFS_UP, OFS_PACC, OFS_MACC,
    OFS_STAT, OFS_SPEED, 8'h24};
  logic [31:0] rv[9] = '{32'h1, 32'hA, 32'hA0, 32'h1F4, 32'h64, 32'h64, 32'h0, 32'h0, 32'h0};
  int cu[10] = '{5000, 5001, 8000, 8001, 11000, 11001, 12500, 10160, 12000, 12000};
  int ca[10] = '{5, 5, 6, 6, 7, 7, 8, 1542, 1542, 1543};
  logic [31:0] ep[5] = '{32'hA, 32'hA, 32'h8, 32'hA, 32'hA};
  int el[5] = '{160, 160, 40, 40, 160};
  int eu[5] = '{10160, 180, 5000, 5000, 180};
  logic [2:0] ec[5] = '{CMD_ACCEL, CMD_ACCEL, CMD_LOWER, CMD_LOWER, CMD_PATTERN};
  logic [7:0] es[5] = '{8'h00, 8'h21, 8'h11, 8'h00, 8'h00};
  int ev[5] = '{0, 0, 0, 160, 160};

  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  acp_axis #(.TICK_CYCLES(2560)) u_acp_axis (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pulse_out(pulse_out), .dir_out(dir_out));
  acp_motor_model u_acp_motor_model (.pclk(pclk), .presetn(presetn), .pulse_in(pulse_out),
    .dir_in(dir_out));

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    s = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input int d);
    apb(1'b1, ad, 32'(d));
  endtask

  task automatic rd(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0000_0000);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // poll state field until it reads k
  task automatic upto(input logic [2:0] k);
    int i;
    i = 0;
    do
    begin
      rd(OFS_STAT);
      i++;
    end while (s[10:8] !== k && i < 20000);
  endtask

  function automatic logic [31:0] near(int x, int y, int t);
    return {31'h0, (x - y <= t) && (y - x <= t)};
  endfunction

  function automatic int lin(int lo, int hi, int l);
    return lo + (hi - lo) * l / 255;
  endfunction

  // parameter check, low speed fixed at 160
  function automatic logic bad(logic fm, int u, int ac);
    if (fm)
      return ac < (u <= 5000 ? 5 : u <= 8000 ? 6 : u <= 11000 ? 7 : 8);
    if (ac < 1 || ac > 1542)
      return 1'b1;
    return (u - 160 + ac - 1) / ac < 8;
  endfunction

  initial
  begin
    void'($urandom(32'h2cef_5685));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      rd(ra[i]);
      chk(s, rv[i]);
      chk({31'h0, perr}, {31'h0, i == 8});
    end
    a = $urandom;
    wr(OFS_PACC, a);
    wr(OFS_MACC, ~a);
    rd(OFS_PACC);
    chk(s, {20'h0, a[11:0]});
    rd(OFS_MACC);
    chk(s, {20'h0, ~a[11:0]});
    wr(OFS_LOW, 160);
    for (int i = 0; i < 22; i++)
    begin
      f = i < 10 ? i < 7 : 1'($urandom % 2);
      up = i < 10 ? cu[i] : 5000 + $urandom % 7500;
      a = i < 10 ? ca[i] : f ? 4 + $urandom % 6 : 1000 + $urandom % 600;
      wr(OFS_PROP2, 8 + f);
      wr(OFS_UP, up);
      wr(OFS_PACC, a);
      wr(OFS_MACC, a);
      wr(OFS_CMD, CMD_ACCEL);
      rd(OFS_STAT);
      chk({31'h0, s[0]}, {31'h0, bad(f, up, a)});
      wr(OFS_CMD, CMD_STOP);
      wr(OFS_STAT, 1);
    end
    wr(OFS_PACC, 1542);
    for (int i = 0; i < 5; i++)
    begin
      wr(OFS_PROP2, ep[i]);
      wr(OFS_LOW, el[i]);
      wr(OFS_UP, eu[i]);
      wr(OFS_CMD, ec[i]);
      rd(OFS_STAT);
      chk({24'h0, s[7:0]}, {24'h0, es[i]});
      rd(OFS_SPEED);
      if (i > 1)
        chk(s, 32'(ev[i]));
      wr(OFS_CMD, CMD_STOP);
      wr(OFS_STAT, 1);
    end
    wr(OFS_PROP2, 32'h0000_000B);
    // curve changed while stopped
    wr(OFS_PROP1, 0);
    wr(OFS_LOW, 160);
    wr(OFS_UP, 5000);
    wr(OFS_PACC, 8);
    wr(OFS_MACC, 8);
    wr(OFS_CMD, CMD_ACCEL | 32'h10);
    n = cyc;
    repeat (64 * 80) @(posedge pclk);
    rd(OFS_STAT);
    lvl = s[23:16];
    rd(OFS_SPEED);
    chk(near(s, lin(160, 5000, lvl), 40), 1);
    upto(ST_UP);
    chk(near(cyc - n, 255 * 80, 24), 1);
    wr(OFS_UP, 12500);
    wr(OFS_CMD, CMD_UPPER);
    rd(OFS_SPEED);
    chk(s, 12500);
    repeat (20000) @(posedge pclk);
    chk({31'h0, u_acp_motor_model.pulses >= 2}, 1);
    chk({31'h0, u_acp_motor_model.last_dir}, 1);
    wr(OFS_CMD, CMD_DECEL);
    repeat (40 * 80) @(posedge pclk);
    rd(OFS_STAT);
    lvl = s[23:16];
    wr(OFS_CMD, CMD_ACCEL);
    n = cyc;
    upto(ST_UP);
    chk(near(cyc - n, (255 - lvl) * 80, 100), 1);
    wr(OFS_CMD, CMD_STOP);
    rd(OFS_SPEED);
    chk(s, 0);
    chk({31'h0, pulse_out}, 0);
    // curve changed while stopped
    wr(OFS_PROP1, 1);
    wr(OFS_CMD, CMD_ACCEL);
    repeat (64 * 80) @(posedge pclk);
    rd(OFS_STAT);
    lvl = s[23:16];
    rd(OFS_SPEED);
    chk({31'h0, s + 200 < lin(160, 12500, lvl)}, 1);
    wr(OFS_CMD, CMD_DECEL);
    repeat (20 * 80) @(posedge pclk);
    rd(OFS_STAT);
    lvl = s[23:16];
    rd(OFS_SPEED);
    chk({31'h0, s + 200 < lin(160, 12500, lvl)}, 1);
    chk({31'h0, dir_out}, 0);
    end_sim;
  end

  initial
  begin
    repeat (90000) @(posedge pclk);
    mismatches++;
    end_sim;
  end
endmodule
